// *** bfc_defs.svh ***
`ifndef BFC_DEFS_SVH
`define BFC_DEFS_SVH

// ----------------------------------------------------------------
// register map (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define BFC_OFF_CTRL     8'h00
`define BFC_OFF_ADDR     8'h04
`define BFC_OFF_WDATA    8'h08
`define BFC_OFF_CMD      8'h0c
`define BFC_OFF_GSRADDR  8'h10
`define BFC_OFF_STATUS   8'h14
`define BFC_OFF_RDATA    8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BFC_CTRL_GO      0
`define BFC_CTRL_OP_LO   1
`define BFC_CTRL_OP_HI   3
`define BFC_CTRL_WORD    8
`define BFC_CTRL_WP      9
`define BFC_CTRL_PD      10
`define BFC_ST_BUSY      0
`define BFC_ST_READY     1
`define BFC_ST_DONE      2
`define BFC_ST_QFULL     3
`define BFC_ST_REJECT    4
`define BFC_ST_RBPULSE   5
`define BFC_GSR_QFULL    3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BFC_RST_CTRL     3'h0
`define BFC_RST_ADDR     21'h000000
`define BFC_RST_DATA     16'h0000
`define BFC_RST_GSRADDR  21'h000002

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BFC_CLK_NS       10
`define BFC_T_SETUP_NS   20
`define BFC_T_WPULSE_NS  60
`define BFC_T_RPULSE_NS  100
`define BFC_T_HOLD_NS    20
`define BFC_SETUP_CYC    ((`BFC_T_SETUP_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS)
`define BFC_WPULSE_CYC   ((`BFC_T_WPULSE_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS)
`define BFC_RPULSE_CYC   ((`BFC_T_RPULSE_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS)
`define BFC_HOLD_CYC     ((`BFC_T_HOLD_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS)

`endif

// *** bfc_pkg.sv ***
package bfc_pkg;

  typedef enum logic [2:0] {
    BFC_OP_READ    = 3'h0,
    BFC_OP_WRITE   = 3'h1,
    BFC_OP_SEQ2    = 3'h2,
    BFC_OP_SEQ2CHK = 3'h3,
    BFC_OP_WAITRDY = 3'h4
  } bfc_op_t;

  typedef enum logic [5:0] {
    BFC_M_IDLE  = 6'h01,
    BFC_M_CHECK = 6'h02,
    BFC_M_CMD   = 6'h04,
    BFC_M_DATA  = 6'h08,
    BFC_M_READ  = 6'h10,
    BFC_M_WAIT  = 6'h20
  } bfc_main_t;

  typedef enum logic [3:0] {
    BFC_C_IDLE  = 4'h1,
    BFC_C_SETUP = 4'h2,
    BFC_C_PULSE = 4'h4,
    BFC_C_HOLD  = 4'h8
  } bfc_cyc_t;

endpackage

// *** bfc_bus_cycle.sv ***
`timescale 1ns/100ps
`include "bfc_defs.svh"

module bfc_bus_cycle (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic        word_mode,
  input  wire logic [20:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] dq_sync,
  output logic             done,
  output logic [15:0]      rdata,
  output logic [20:0]      flash_addr,
  output logic [15:0]      dq_out,
  output logic             dq_oe_lo,
  output logic             dq_oe_hi,
  output logic             chip_enable_a_n,
  output logic             chip_enable_b_n,
  output logic             write_enable_n,
  output logic             output_enable_n
);

  bfc_pkg::bfc_cyc_t st_q, st_d;
  logic [7:0]  cnt_q, cnt_d;
  logic        wr_q, wr_d;
  logic [20:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d;
  logic [15:0] rdata_q, rdata_d;
  logic        done_q, done_d;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    wr_d    = wr_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    done_d  = 1'b0;
    case (st_q)
      bfc_pkg::BFC_C_IDLE: begin
        if (start) begin
          wr_d    = is_write;
          addr_d  = addr;
          wdata_d = wdata;
          cnt_d   = 8'(`BFC_SETUP_CYC - 1);
          st_d    = bfc_pkg::BFC_C_SETUP;
        end
      end
      bfc_pkg::BFC_C_SETUP: begin
        if (cnt_q == 8'h00) begin
          cnt_d = wr_q ? 8'(`BFC_WPULSE_CYC - 1) : 8'(`BFC_RPULSE_CYC - 1);
          st_d  = bfc_pkg::BFC_C_PULSE;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      bfc_pkg::BFC_C_PULSE: begin
        if (cnt_q == 8'h00) begin
          // synced data lags the pins by two cycles; read pulse covers access time plus that
          if (!wr_q)
            rdata_d = word_mode ? dq_sync : {8'h00, dq_sync[7:0]};
          cnt_d = 8'(`BFC_HOLD_CYC - 1);
          st_d  = bfc_pkg::BFC_C_HOLD;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      bfc_pkg::BFC_C_HOLD: begin
        if (cnt_q == 8'h00) begin
          done_d = 1'b1;
          st_d   = bfc_pkg::BFC_C_IDLE;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: st_d = bfc_pkg::BFC_C_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= bfc_pkg::BFC_C_IDLE;
      cnt_q   <= 8'h00;
      wr_q    <= 1'b0;
      addr_q  <= `BFC_RST_ADDR;
      wdata_q <= `BFC_RST_DATA;
      rdata_q <= `BFC_RST_DATA;
      done_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      wr_q    <= wr_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      done_q  <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // pin decode
  // ----------------------------------------------------------------
  // both enables fall together and rise together in hold to deselect
  assign chip_enable_a_n = !(st_q == bfc_pkg::BFC_C_SETUP || st_q == bfc_pkg::BFC_C_PULSE);
  assign chip_enable_b_n = chip_enable_a_n;
  assign write_enable_n  = !(st_q == bfc_pkg::BFC_C_PULSE && wr_q);
  assign output_enable_n = !(st_q == bfc_pkg::BFC_C_PULSE && !wr_q);
  // lane bit only meaningful in byte mode; held low otherwise
  assign flash_addr = {addr_q[20:1], addr_q[0] & !word_mode};
  assign dq_out     = wdata_q;
  assign dq_oe_lo   = wr_q && (st_q != bfc_pkg::BFC_C_IDLE);
  assign dq_oe_hi   = dq_oe_lo && word_mode;
  assign done       = done_q;
  assign rdata      = rdata_q;

endmodule // bfc_bus_cycle

// *** bfc_host.sv ***
// Contract
// - program or block erase starts with a two-cycle command sequence
// - every operation starts with a command sequence; progress via status and ready (the read and wait-ready ops here issue no command cycle)
// - host reconfigures ready/busy by command; pulse on completion possible
// - after upload host swaps page buffer then reads it
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "bfc_defs.svh"

module bfc_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [20:0]      flash_addr,
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq_out,
  output logic             dq_oe_lo,
  output logic             dq_oe_hi,
  output logic             chip_enable_a_n,
  output logic             chip_enable_b_n,
  output logic             write_enable_n,
  output logic             output_enable_n,
  output logic             width_select,
  output logic             write_protect_n,
  output logic             powerdown_reset_n,
  input  wire logic        ready_busy_out_n
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [15:0] dq_s1_q, dq_s2_q;
  logic        rb_s1_q, rb_s2_q, rb_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1_q   <= 16'h0000;
      dq_s2_q   <= 16'h0000;
      // released line idles high; a low reset value would fake a rising edge
      rb_s1_q   <= 1'b1;
      rb_s2_q   <= 1'b1;
      rb_prev_q <= 1'b1;
    end else begin
      dq_s1_q   <= dq_in;
      dq_s2_q   <= dq_s1_q;
      rb_s1_q   <= ready_busy_out_n;
      rb_s2_q   <= rb_s1_q;
      rb_prev_q <= rb_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [2:0]  ctrl_q, ctrl_d;       // {pd, wp, word}
  logic [20:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d;
  logic [15:0] cmd_q, cmd_d;
  logic [20:0] gsr_addr_q, gsr_addr_d;
  logic [5:2]  sticky_q, sticky_d;   // rbpulse, reject, qfull, done
  logic [31:0] prdata_q, prdata_d;
  logic        wr_acc, go, busy, mapped;
  logic        cyc_done;
  logic [15:0] cyc_rdata;
  logic        set_done, set_qfull;
  bfc_pkg::bfc_main_t st_q, st_d;

  assign wr_acc = psel && penable && pwrite;
  assign mapped = (paddr <= `BFC_OFF_RDATA) && (paddr[1:0] == 2'b00);
  assign go     = wr_acc && paddr == `BFC_OFF_CTRL && pwdata[`BFC_CTRL_GO];
  assign busy   = (st_q != bfc_pkg::BFC_M_IDLE);

  always_comb begin
    ctrl_d     = ctrl_q;
    addr_d     = addr_q;
    wdata_d    = wdata_q;
    cmd_d      = cmd_q;
    gsr_addr_d = gsr_addr_q;
    sticky_d   = sticky_q;
    prdata_d   = prdata_q;
    if (wr_acc) begin
      case (paddr)
        `BFC_OFF_CTRL:    ctrl_d = {pwdata[`BFC_CTRL_PD], pwdata[`BFC_CTRL_WP],
                                    pwdata[`BFC_CTRL_WORD]};
        `BFC_OFF_ADDR:    addr_d = pwdata[20:0];
        `BFC_OFF_WDATA:   wdata_d = pwdata[15:0];
        `BFC_OFF_CMD:     cmd_d = pwdata[15:0];
        `BFC_OFF_GSRADDR: gsr_addr_d = pwdata[20:0];
        `BFC_OFF_STATUS:  sticky_d = sticky_q & ~pwdata[5:2];
        default: ;
      endcase
    end
    // hardware sets override a same-cycle software clear
    if (set_done)
      sticky_d[`BFC_ST_DONE] = 1'b1;
    if (set_qfull)
      sticky_d[`BFC_ST_QFULL] = 1'b1;
    if (go && (busy || ctrl_q[2]))
      sticky_d[`BFC_ST_REJECT] = 1'b1;
    // released line returning high marks a completion pulse
    if (rb_s2_q && !rb_prev_q)
      sticky_d[`BFC_ST_RBPULSE] = 1'b1;
    if (psel && !penable) begin
      case (paddr)
        `BFC_OFF_CTRL:    prdata_d = {21'h000000, ctrl_q, 8'h00};
        `BFC_OFF_ADDR:    prdata_d = {11'h000, addr_q};
        `BFC_OFF_WDATA:   prdata_d = {16'h0000, wdata_q};
        `BFC_OFF_CMD:     prdata_d = {16'h0000, cmd_q};
        `BFC_OFF_GSRADDR: prdata_d = {11'h000, gsr_addr_q};
        `BFC_OFF_STATUS:  prdata_d = {26'h0000000, sticky_q, rb_s2_q, busy};
        `BFC_OFF_RDATA:   prdata_d = {16'h0000, cyc_rdata};
        default:          prdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= `BFC_RST_CTRL;
      addr_q     <= `BFC_RST_ADDR;
      wdata_q    <= `BFC_RST_DATA;
      cmd_q      <= `BFC_RST_DATA;
      gsr_addr_q <= `BFC_RST_GSRADDR;
      sticky_q   <= 4'h0;
      prdata_q   <= 32'h00000000;
    end else begin
      ctrl_q     <= ctrl_d;
      addr_q     <= addr_d;
      wdata_q    <= wdata_d;
      cmd_q      <= cmd_d;
      gsr_addr_q <= gsr_addr_d;
      sticky_q   <= sticky_d;
      prdata_q   <= prdata_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic        start_q, start_d;
  logic        cwr_q, cwr_d;
  logic [20:0] caddr_q, caddr_d;
  logic [15:0] cdata_q, cdata_d;
  bfc_pkg::bfc_op_t op;

  assign op = bfc_pkg::bfc_op_t'(pwdata[`BFC_CTRL_OP_HI:`BFC_CTRL_OP_LO]);

  always_comb begin
    st_d      = st_q;
    start_d   = 1'b0;
    cwr_d     = cwr_q;
    caddr_d   = caddr_q;
    cdata_d   = cdata_q;
    set_done  = 1'b0;
    set_qfull = 1'b0;
    case (st_q)
      bfc_pkg::BFC_M_IDLE: begin
        // upload readout is a swap sequence followed by plain reads
        if (go && !ctrl_q[2]) begin
          caddr_d = addr_q;
          cdata_d = cmd_q;
          cwr_d   = 1'b1;
          start_d = 1'b1;
          case (op)
            bfc_pkg::BFC_OP_READ: begin
              cwr_d = 1'b0;
              st_d  = bfc_pkg::BFC_M_READ;
            end
            bfc_pkg::BFC_OP_WRITE:   st_d = bfc_pkg::BFC_M_DATA;
            bfc_pkg::BFC_OP_SEQ2:    st_d = bfc_pkg::BFC_M_CMD;
            bfc_pkg::BFC_OP_SEQ2CHK: begin
              caddr_d = gsr_addr_q;
              cwr_d   = 1'b0;
              st_d    = bfc_pkg::BFC_M_CHECK;
            end
            bfc_pkg::BFC_OP_WAITRDY: begin
              start_d = 1'b0;
              st_d    = bfc_pkg::BFC_M_WAIT;
            end
            default: begin
              start_d = 1'b0;
              set_done = 1'b1;
            end
          endcase
        end
      end
      bfc_pkg::BFC_M_CHECK: begin
        if (cyc_done) begin
          // a full queue would drop the request, so refuse it here
          if (cyc_rdata[`BFC_GSR_QFULL]) begin
            set_qfull = 1'b1;
            st_d      = bfc_pkg::BFC_M_IDLE;
          end else begin
            caddr_d = addr_q;
            cwr_d   = 1'b1;
            start_d = 1'b1;
            st_d    = bfc_pkg::BFC_M_CMD;
          end
        end
      end
      bfc_pkg::BFC_M_CMD: begin
        if (cyc_done) begin
          cdata_d = wdata_q;
          start_d = 1'b1;
          st_d    = bfc_pkg::BFC_M_DATA;
        end
      end
      bfc_pkg::BFC_M_DATA, bfc_pkg::BFC_M_READ: begin
        if (cyc_done) begin
          set_done = 1'b1;
          st_d     = bfc_pkg::BFC_M_IDLE;
        end
      end
      bfc_pkg::BFC_M_WAIT: begin
        // line is released high by every device on it when all are ready
        if (rb_s2_q) begin
          set_done = 1'b1;
          st_d     = bfc_pkg::BFC_M_IDLE;
        end
      end
      default: st_d = bfc_pkg::BFC_M_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= bfc_pkg::BFC_M_IDLE;
      start_q <= 1'b0;
      cwr_q   <= 1'b0;
      caddr_q <= `BFC_RST_ADDR;
      cdata_q <= `BFC_RST_DATA;
    end else begin
      st_q    <= st_d;
      start_q <= start_d;
      cwr_q   <= cwr_d;
      caddr_q <= caddr_d;
      cdata_q <= cdata_d;
    end
  end

  // ----------------------------------------------------------------
  // static pins
  // ----------------------------------------------------------------
  assign width_select      = ctrl_q[0];
  assign write_protect_n   = !ctrl_q[1];
  // holding the pin low aborts device work and clears its status
  assign powerdown_reset_n = !ctrl_q[2];

  bfc_bus_cycle u_cycle (
    .pclk            (pclk),
    .presetn         (presetn),
    .start           (start_q),
    .is_write        (cwr_q),
    .word_mode       (ctrl_q[0]),
    .addr            (caddr_q),
    .wdata           (cdata_q),
    .dq_sync         (dq_s2_q),
    .done            (cyc_done),
    .rdata           (cyc_rdata),
    .flash_addr      (flash_addr),
    .dq_out          (dq_out),
    .dq_oe_lo        (dq_oe_lo),
    .dq_oe_hi        (dq_oe_hi),
    .chip_enable_a_n (chip_enable_a_n),
    .chip_enable_b_n (chip_enable_b_n),
    .write_enable_n  (write_enable_n),
    .output_enable_n (output_enable_n)
  );

endmodule // bfc_host

// *** bfc_host_asserts.sv ***
`timescale 1ns/100ps
module bfc_host_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pslverr,
  input wire logic [20:0] flash_addr,
  input wire logic [15:0] dq_out,
  input wire logic        dq_oe_lo,
  input wire logic        dq_oe_hi,
  input wire logic        chip_enable_a_n,
  input wire logic        chip_enable_b_n,
  input wire logic        write_enable_n,
  input wire logic        output_enable_n,
  input wire logic        width_select,
  input wire logic        powerdown_reset_n
);
  // ------------------------------
  // strobe and pin discipline
  // ------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_CE_PAIR: assert property (chip_enable_a_n == chip_enable_b_n)
    else $error("chip enables differ");
  AST_WE_SEL: assert property (!write_enable_n |-> !chip_enable_a_n && !chip_enable_b_n)
    else $error("write strobe without select");
  AST_OE_SEL: assert property (!output_enable_n |-> !chip_enable_a_n && !chip_enable_b_n)
    else $error("read strobe without select");
  AST_WE_SETUP: assert property ($fell(write_enable_n) |->
    $past(!chip_enable_a_n, 2) && $past(chip_enable_a_n, 3)) else $error("setup not two cycles");
  AST_WE_WIDTH: assert property ($fell(write_enable_n) |-> !write_enable_n[*6] ##1 write_enable_n)
    else $error("write pulse width wrong");
  AST_OE_WIDTH: assert property ($fell(output_enable_n) |-> ##9 !output_enable_n ##1 output_enable_n)
    else $error("read pulse width wrong");
  AST_WR_DATA: assert property (!write_enable_n |-> dq_oe_lo && $stable(dq_out) && $stable(flash_addr))
    else $error("data or address moved in write pulse");
  AST_WR_HOLD: assert property ($rose(write_enable_n) |-> dq_oe_lo && $stable(dq_out))
    else $error("data released at strobe rise");
  AST_HI_WORD: assert property (dq_oe_hi |-> width_select)
    else $error("high byte driven in byte mode");
  AST_LANE_WORD: assert property (width_select && !chip_enable_a_n |-> !flash_addr[0])
    else $error("lane bit set in word mode");
  AST_PD_QUIET: assert property (!powerdown_reset_n |-> write_enable_n && output_enable_n)
    else $error("strobe during power-down");
  AST_NO_FIGHT: assert property (!output_enable_n |-> !dq_oe_lo && !dq_oe_hi)
    else $error("host drives data while reading");
  AST_UNMAPPED: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
    else $error("unmapped access without error");

  cover property ($fell(write_enable_n));
  cover property ($fell(output_enable_n));
  cover property (dq_oe_hi && !write_enable_n);
  cover property (psel && penable && pslverr);
endmodule // bfc_host_asserts

bind bfc_host bfc_host_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pslverr(pslverr), .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe_lo(dq_oe_lo),
  .dq_oe_hi(dq_oe_hi), .chip_enable_a_n(chip_enable_a_n), .chip_enable_b_n(chip_enable_b_n),
  .write_enable_n(write_enable_n), .output_enable_n(output_enable_n),
  .width_select(width_select), .powerdown_reset_n(powerdown_reset_n)
);

// *** bfc_flash_model.sv ***
`timescale 1ns/100ps
module bfc_flash_model #(
  parameter logic [7:0] PROG_CMD   = 8'h10,
  parameter logic [4:0] LOCKED_BLK = 5'h01,
  parameter bit         VPP_OK     = 1'b1,
  parameter int         BUSY_NS    = 300
) (
  input  wire logic [20:0] addr,
  input  wire logic [15:0] dq,
  input  wire logic        ce_a_n,
  input  wire logic        ce_b_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        word_mode,
  input  wire logic        wp_n,
  input  wire logic        pd_n,
  output logic      [15:0] dq_m,
  output logic             rb_pull
);
  // ------------------------------
  // small array window, one word per index
  // ------------------------------
  logic [15:0] mem [0:15];
  logic [31:0] lock;
  logic [15:0] last;
  logic        armed;
  wire         sel   = !ce_a_n && !ce_b_n;
  wire  [3:0]  wi    = addr[4:1];
  wire         drive = sel && !oe_n && pd_n;
  // write ends at whichever of strobe or select rises first
  wire         wr_act = sel && !we_n;
  wire  [15:0] rd_v  = word_mode ? mem[wi] : {8'h00, addr[0] ? mem[wi][15:8] : mem[wi][7:0]};

  initial begin
    foreach (mem[i]) mem[i] = 16'hffff;
    lock = 32'h1 << LOCKED_BLK;
    last = 16'h0000;
    armed = 1'b0;
    rb_pull = 1'b0;
  end

  // released bus shows the inverse so a stale value never passes
  assign dq_m = drive ? rd_v : ~last;
  always @(negedge drive) last = rd_v;

  always @(negedge pd_n) begin
    armed = 1'b0;
    rb_pull = 1'b0;
  end

  always @(negedge wr_act) begin
    if (pd_n) begin
      if (!armed) begin
        armed = (dq[7:0] == PROG_CMD);
      end else begin
        armed = 1'b0;
        if (VPP_OK && !(!wp_n && lock[addr[20:16]])) begin
          if (word_mode) mem[wi] = dq;
          else if (addr[0]) mem[wi][15:8] = dq[7:0];
          else mem[wi][7:0] = dq[7:0];
          rb_pull = 1'b1;
          rb_pull <= #(BUSY_NS) 1'b0;
        end
      end
    end
  end
endmodule // bfc_flash_model

// *** block_flash_command_interface_tb_top.sv ***
`timescale 1ns/100ps
`include "bfc_defs.svh"
module block_flash_command_interface_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv, m_v;
  logic [20:0] flash_addr;
  logic [15:0] dq_in, dq_out, dq_m, d0, d1;
  logic        dq_oe_lo, dq_oe_hi, ce_a_n, ce_b_n, we_n, oe_n, width_select;
  logic        write_protect_n, powerdown_reset_n, rb_pull;
  wire         ready_busy_out_n = rb_pull ? 1'b0 : 1'b1;
  logic [31:0] exp_q[$], msk_q[$];
  int          fail_count = 0;
  int          n_compared = 0;

  assign dq_in = {dq_oe_hi ? dq_out[15:8] : dq_m[15:8], dq_oe_lo ? dq_out[7:0] : dq_m[7:0]};

  bfc_host dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_addr(flash_addr), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_lo(dq_oe_lo), .dq_oe_hi(dq_oe_hi), .chip_enable_a_n(ce_a_n),
    .chip_enable_b_n(ce_b_n), .write_enable_n(we_n), .output_enable_n(oe_n),
    .width_select(width_select), .write_protect_n(write_protect_n),
    .powerdown_reset_n(powerdown_reset_n), .ready_busy_out_n(ready_busy_out_n));

  bfc_flash_model u_flash (.addr(flash_addr), .dq(dq_in), .ce_a_n(ce_a_n), .ce_b_n(ce_b_n),
    .we_n(we_n), .oe_n(oe_n), .word_mode(width_select), .wp_n(write_protect_n),
    .pd_n(powerdown_reset_n), .dq_m(dq_m), .rb_pull(rb_pull));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ------------------------------
  // checking and closing
  // ------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
      m_v = msk_q.pop_front();
      chk(prdata & m_v, exp_q.pop_front());
    end
  end

  // ------------------------------
  // bus tasks
  // ------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rv = prdata;
    if (n >= 50) begin
      fail_count++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_st(input logic [31:0] m);
    int n;
    for (n = 0; n < 300; n++) begin
      apb(1'b0, `BFC_OFF_STATUS, 32'h0);
      if ((rv & m) != 32'h0) break;
    end
    if (n >= 300) begin
      fail_count++;
      end_sim();
    end
  endtask

  task automatic go(input logic [2:0] op, input logic wd, input logic wp, input logic pd);
    apb(1'b1, `BFC_OFF_CTRL, {21'h0, pd, wp, wd, 4'h0, op, 1'b1});
  endtask

  task automatic op_run(input logic [2:0] op, input logic wd, input logic wp);
    go(op, wd, wp, 1'b0);
    wait_st(32'h4);
    apb(1'b1, `BFC_OFF_STATUS, 32'h3c);
  endtask

  task automatic prog(input logic [20:0] a, input logic [15:0] d, input logic wd,
                      input logic wp, input logic pulse);
    apb(1'b1, `BFC_OFF_ADDR, {11'h0, a});
    apb(1'b1, `BFC_OFF_CMD, 32'h10);
    apb(1'b1, `BFC_OFF_WDATA, {16'h0, d});
    op_run(3'h2, wd, wp);
    op_run(3'h4, wd, wp);
    apb(1'b1, `BFC_OFF_STATUS, 32'h3c);
    exp_q.push_back({26'h0, pulse, 5'h0});
    msk_q.push_back(32'h0);
  endtask

  // completion pulse is checked by reading status after the ready wait, before clearing
  task automatic prog_chk(input logic [20:0] a, input logic [15:0] d, input logic wd,
                          input logic wp, input logic pulse);
    apb(1'b1, `BFC_OFF_ADDR, {11'h0, a});
    apb(1'b1, `BFC_OFF_CMD, 32'h10);
    apb(1'b1, `BFC_OFF_WDATA, {16'h0, d});
    op_run(3'h2, wd, wp);
    go(3'h4, wd, wp, 1'b0);
    wait_st(32'h4);
    rd(`BFC_OFF_STATUS, {26'h0, pulse, 5'h06}, 32'h3f);
    apb(1'b1, `BFC_OFF_STATUS, 32'h3c);
  endtask

  task automatic rdback(input logic [20:0] a, input logic wd, input logic [31:0] e);
    apb(1'b1, `BFC_OFF_ADDR, {11'h0, a});
    op_run(3'h0, wd, 1'b0);
    rd(`BFC_OFF_RDATA, e, 32'hffffffff);
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(32'h568c31ab));
    d0 = 16'($urandom()) & 16'hfff7;
    d1 = 16'($urandom());
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`BFC_OFF_CTRL, 32'h0, 32'hffffffff);
    rd(`BFC_OFF_GSRADDR, 32'h2, 32'hffffffff);
    rd(`BFC_OFF_STATUS, 32'h2, 32'h3f);
    rd(8'h1c, 32'h0, 32'hffffffff);
    prog_chk(21'h000013, d0, 1'b1, 1'b0, 1'b1);
    rdback(21'h000012, 1'b1, {16'h0, d0});
    prog_chk(21'h000020, {8'h0, d1[7:0]}, 1'b0, 1'b0, 1'b1);
    prog_chk(21'h000021, {8'h0, d1[15:8]}, 1'b0, 1'b0, 1'b1);
    rdback(21'h000021, 1'b0, {24'h0, d1[15:8]});
    rdback(21'h000020, 1'b1, {16'h0, d1});
    prog_chk(21'h010004, d0, 1'b1, 1'b1, 1'b0);
    rdback(21'h010004, 1'b1, 32'hffff);
    prog_chk(21'h010004, d1, 1'b1, 1'b0, 1'b1);
    rdback(21'h010004, 1'b1, {16'h0, d1});
    go(3'h0, 1'b1, 1'b0, 1'b0);
    go(3'h0, 1'b1, 1'b0, 1'b0);
    rd(`BFC_OFF_STATUS, 32'h10, 32'h10);
    wait_st(32'h4);
    apb(1'b1, `BFC_OFF_STATUS, 32'h3c);
    apb(1'b1, `BFC_OFF_CTRL, 32'h500);
    go(3'h0, 1'b1, 1'b0, 1'b1);
    rd(`BFC_OFF_STATUS, 32'h10, 32'h10);
    rd(`BFC_OFF_CTRL, 32'h500, 32'hffffffff);
    apb(1'b1, `BFC_OFF_CTRL, 32'h100);
    apb(1'b1, `BFC_OFF_STATUS, 32'h3c);
    go(3'h3, 1'b1, 1'b0, 1'b0);
    wait_st(32'h8);
    rd(`BFC_OFF_STATUS, 32'h8, 32'h8);
    apb(1'b1, `BFC_OFF_GSRADDR, 32'h12);
    apb(1'b1, `BFC_OFF_ADDR, 32'h18);
    apb(1'b1, `BFC_OFF_WDATA, {16'h0, d1});
    op_run(3'h3, 1'b1, 1'b0);
    rdback(21'h000018, 1'b1, {16'h0, d1});
    apb(1'b1, `BFC_OFF_ADDR, 32'h1a);
    op_run(3'h1, 1'b1, 1'b0);
    apb(1'b1, `BFC_OFF_CMD, {16'h0, d0});
    op_run(3'h1, 1'b1, 1'b0);
    rdback(21'h00001a, 1'b1, {16'h0, d0});
    repeat (20) @(posedge pclk);
    end_sim();
  end
endmodule // block_flash_command_interface_tb_top
